// ---- rtl/adc_cfg_pkg.sv ----
// constants, encodings and register map of the conversion/output config block
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register
package adc_cfg_pkg;
  // register indices and byte addresses
  localparam int IDX_CONFIG = 4;
  localparam int IDX_IRQ = 5;
  localparam logic [7:0] ADDR_CONFIG = 8'(4 * IDX_CONFIG);
  localparam logic [7:0] ADDR_IRQ = 8'(4 * IDX_IRQ);
  localparam logic [7:0] ADDR_OPCTL = 8'h20;
  localparam logic [7:0] ADDR_OFFSET = 8'h24;
  localparam logic [7:0] ADDR_GAIN = 8'h28;
  localparam logic [7:0] ADDR_RESULT = 8'h2C;
  localparam logic [7:0] ADDR_INTSTAT = 8'h30;
  localparam logic [7:0] ADDR_INTEN = 8'h34;
  localparam logic [7:0] ADDR_INTCLR = 8'h38;
  // conversion_output_config fields
  localparam int CFG_MODE_LSB = 6;
  localparam int CFG_FMT_LSB = 4;
  localparam int CFG_CKW_BIT = 3;
  localparam int CFG_CKE_BIT = 2;
  localparam int CFG_OFF_BIT = 1;
  localparam int CFG_GAIN_BIT = 0;
  // interrupt_status_control field
  localparam int IRQ_FLAG_BIT = 6;
  // operating control fields
  localparam int OPC_AZ_BIT = 2;
  // interrupt status bits
  localparam int INT_DONE = 0;
  localparam int INT_ONESHOT = 1;
  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [1:0] OPSTATE_RST = 2'h0;
  localparam logic [23:0] OFFSET_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST = 24'h800000;
  // conversion modes and operating states
  localparam logic [1:0] MODE_CONT = 2'h3;
  localparam logic [1:0] MODE_STBY = 2'h2;
  localparam logic [1:0] OP_CONV = 2'h3;
  localparam logic [1:0] OP_STBY = 2'h2;
  localparam logic [1:0] OP_SHDN = 2'h0;
  // output formats
  localparam logic [1:0] FMT_24 = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_SX = 2'h2;
  localparam logic [1:0] FMT_TAG = 2'h3;
  // saturation codes of the 24-bit formats
  localparam logic [23:0] SAT_POS = 24'hFFFFFF;
  localparam logic [23:0] SAT_NEG = 24'h800000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {ENG_IDLE, ENG_CONV} eng_e;
endpackage

// ---- rtl/adc_conversion_output_config.sv ----
// register bank and conversion sequencing of the converter's output config
// assumes AXI4-Lite master, sample source and serial shifter all on sys_clk
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Function
// - mode 11 converts continuously until the operating state leaves converting.
// - mode 10 does one conversion and then sets the operating state to standby 10.
// - mode 0x does one conversion and then sets the operating state to shutdown 00.
// - format 00 gives a bare 24-bit result saturated at 0xFFFFFF or 0x800000.
// - format 01 gives the saturated 24-bit result in the upper bits over eight zeros.
// - format 10 gives eight sign bits above the result so overrange shows.
// - format 11 gives a 4-bit channel tag, four sign bits, then the result.
// - the checksum-width bit picks 32-bit read checksums when 1, 16-bit when 0.
// - checksum width reaches only the serial read path, not the integrity checksum.
// - the read-checksum enable turns read checksums on and leaves integrity alone.
// - offset correction is applied only while its enable is 1, reset off.
// - gain correction is applied only while its enable is 1, reset off.
// - the 8-bit read/write config register sits at index 0x4 and resets to zero.
// - with auto-zero on a continuous request becomes repeated single conversions.
// - the ready flag drops to 0 on a new result and returns to 1 when the result register is read.
module adc_conversion_output_config
  import adc_cfg_pkg::*;
#(
  parameter int RAW_W = 25
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sample source
  input wire logic sampleValid,
  input wire logic [RAW_W-1:0] sampleData,
  input wire logic [3:0] sampleTag,
  output logic convStart,
  output logic convActive,
  output logic [1:0] opState,
  // serial read path
  input wire logic shiftBusy,
  output logic [31:0] resultWord,
  output logic resultWide,
  output logic resultStrobe,
  output logic readChecksumEnable,
  output logic readChecksumWide,
  // integrity checksum source
  output logic [7:0] configImage,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic haveAw;
    logic haveW;
    logic [7:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic arReady;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [7:0] cfgReg;
    logic [1:0] opState;
    logic autoZero;
    logic [23:0] offset;
    logic [23:0] gain;
    eng_e eng;
    logic [1:0] runMode;
    logic [1:0] runFmt;
    logic runOff;
    logic runGain;
    logic [31:0] result;
    logic readyFlag;
    logic [31:0] outWord;
    logic outWide;
    logic outStrobe;
    logic pendValid;
    logic [31:0] pendWord;
    logic pendWide;
    logic convStart;
    logic [1:0] intStatus;
    logic [1:0] intEnable;
    logic irq;
  } state_s;

  state_s s;
  state_s next_s;
  logic [31:0] fmtWord;

  // ----------------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------------
  result_formatter #(
    .RAW_W(RAW_W),
    .DATA_W(24)
  ) formatter (
    .rawSample($signed(sampleData)),
    .tag(sampleTag),
    .offset(s.offset),
    .gain(s.gain),
    .offsetEn(s.runOff),
    .gainEn(s.runGain),
    .format(s.runFmt),
    .word(fmtWord)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = dat[8*i +: 8];
    end
    return res;
  endfunction

  function automatic logic [33:0] readMux(input state_s r, input logic [7:0] addr);
    logic [33:0] res;
    res = {RESP_OKAY, 32'h0};
    case (addr)
      ADDR_CONFIG: res[31:0] = {24'h0, r.cfgReg};
      ADDR_IRQ: res[IRQ_FLAG_BIT] = r.readyFlag;
      ADDR_OPCTL: res[31:0] = {29'h0, r.autoZero, r.opState};
      ADDR_OFFSET: res[31:0] = {8'h0, r.offset};
      ADDR_GAIN: res[31:0] = {8'h0, r.gain};
      ADDR_RESULT: res[31:0] = r.result;
      ADDR_INTSTAT: res[31:0] = {30'h0, r.intStatus};
      ADDR_INTEN: res[31:0] = {30'h0, r.intEnable};
      ADDR_INTCLR: res[31:0] = 32'h0;
      default: res[33:32] = RESP_SLVERR;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] wv;
    logic [33:0] rd;
    next_s = s;
    wv = 32'h0;
    rd = 34'h0;
    next_s.outStrobe = 1'b0;
    next_s.convStart = 1'b0;
    // write address and data, either order
    if (s_axi_awvalid && s.awReady)
    begin
      next_s.haveAw = 1'b1;
      next_s.awReady = 1'b0;
      next_s.wAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wReady)
    begin
      next_s.haveW = 1'b1;
      next_s.wReady = 1'b0;
      next_s.wData = s_axi_wdata;
      next_s.wStrb = s_axi_wstrb;
    end
    if (s.bValid && s_axi_bready)
    begin
      next_s.bValid = 1'b0;
      next_s.awReady = 1'b1;
      next_s.wReady = 1'b1;
    end
    if (s.haveAw && s.haveW && !s.bValid)
    begin
      next_s.haveAw = 1'b0;
      next_s.haveW = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = RESP_OKAY;
      case (s.wAddr)
        ADDR_CONFIG:
        begin
          wv = merge({24'h0, s.cfgReg}, s.wData, s.wStrb);
          next_s.cfgReg = wv[7:0];
        end
        ADDR_IRQ, ADDR_RESULT, ADDR_INTSTAT:
          next_s.bResp = RESP_OKAY;
        ADDR_OPCTL:
        begin
          wv = merge({29'h0, s.autoZero, s.opState}, s.wData, s.wStrb);
          next_s.opState = wv[1:0];
          next_s.autoZero = wv[OPC_AZ_BIT];
        end
        ADDR_OFFSET:
        begin
          wv = merge({8'h0, s.offset}, s.wData, s.wStrb);
          next_s.offset = wv[23:0];
        end
        ADDR_GAIN:
        begin
          wv = merge({8'h0, s.gain}, s.wData, s.wStrb);
          next_s.gain = wv[23:0];
        end
        ADDR_INTEN:
        begin
          wv = merge({30'h0, s.intEnable}, s.wData, s.wStrb);
          next_s.intEnable = wv[1:0];
        end
        ADDR_INTCLR:
        begin
          wv = merge(32'h0, s.wData, s.wStrb);
          next_s.intStatus = s.intStatus & ~wv[1:0];
        end
        default: next_s.bResp = RESP_SLVERR;
      endcase
    end
    // read channel
    if (s.rValid && s_axi_rready)
    begin
      next_s.rValid = 1'b0;
      next_s.arReady = 1'b1;
    end
    if (s_axi_arvalid && s.arReady)
    begin
      rd = readMux(s, s_axi_araddr);
      next_s.rData = rd[31:0];
      next_s.rResp = rd[33:32];
      next_s.rValid = 1'b1;
      next_s.arReady = 1'b0;
      if (s_axi_araddr == ADDR_RESULT)
        next_s.readyFlag = 1'b1;
    end
    // held word goes out once the shifter is free
    if (s.pendValid && !shiftBusy)
    begin
      next_s.pendValid = 1'b0;
      next_s.outWord = s.pendWord;
      next_s.outWide = s.pendWide;
      next_s.outStrobe = 1'b1;
    end
    // conversion sequencing
    case (s.eng)
      ENG_IDLE:
      begin
        if (s.opState == OP_CONV)
        begin
          next_s.eng = ENG_CONV;
          next_s.convStart = 1'b1;
          next_s.runMode = s.cfgReg[CFG_MODE_LSB +: 2];
          next_s.runFmt = s.cfgReg[CFG_FMT_LSB +: 2];
          next_s.runOff = s.cfgReg[CFG_OFF_BIT];
          next_s.runGain = s.cfgReg[CFG_GAIN_BIT];
        end
      end
      ENG_CONV:
      begin
        if (s.opState != OP_CONV)
          next_s.eng = ENG_IDLE;
        else if (sampleValid)
        begin
          next_s.result = fmtWord;
          next_s.readyFlag = 1'b0;
          next_s.intStatus[INT_DONE] = 1'b1;
          if (shiftBusy || s.pendValid)
          begin
            next_s.pendValid = 1'b1;
            next_s.pendWord = fmtWord;
            next_s.pendWide = (s.runFmt != FMT_24);
          end
          else
          begin
            next_s.outWord = fmtWord;
            next_s.outWide = (s.runFmt != FMT_24);
            next_s.outStrobe = 1'b1;
          end
          if (s.runMode == MODE_CONT)
          begin
            if (s.autoZero)
              next_s.eng = ENG_IDLE;
            else
            begin
              next_s.runMode = s.cfgReg[CFG_MODE_LSB +: 2];
              next_s.runFmt = s.cfgReg[CFG_FMT_LSB +: 2];
              next_s.runOff = s.cfgReg[CFG_OFF_BIT];
              next_s.runGain = s.cfgReg[CFG_GAIN_BIT];
            end
          end
          else if (s.runMode == MODE_STBY)
          begin
            next_s.opState = OP_STBY;
            next_s.eng = ENG_IDLE;
            next_s.intStatus[INT_ONESHOT] = 1'b1;
          end
          else
          begin
            next_s.opState = OP_SHDN;
            next_s.eng = ENG_IDLE;
            next_s.intStatus[INT_ONESHOT] = 1'b1;
          end
        end
      end
      default: next_s.eng = ENG_IDLE;
    endcase
    next_s.irq = |(next_s.intStatus & next_s.intEnable);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
      s.cfgReg <= CONFIG_RST;
      s.opState <= OPSTATE_RST;
      s.offset <= OFFSET_RST;
      s.gain <= GAIN_RST;
      s.eng <= ENG_IDLE;
      s.readyFlag <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s.awReady;
  assign s_axi_wready = s.wReady;
  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = s.arReady;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rresp = s.rResp;
  assign s_axi_rdata = s.rData;
  assign convStart = s.convStart;
  assign convActive = (s.eng == ENG_CONV);
  assign opState = s.opState;
  assign resultWord = s.outWord;
  assign resultWide = s.outWide;
  assign resultStrobe = s.outStrobe;
  assign readChecksumEnable = s.cfgReg[CFG_CKE_BIT];
  assign readChecksumWide = s.cfgReg[CFG_CKW_BIT];
  assign configImage = s.cfgReg;
  assign irq = s.irq;
endmodule

// ---- rtl/result_formatter.sv ----
// calibration, saturation and output word layout of one conversion result
// assumes a signed raw sample one bit wider than the result, same clock, no state
`timescale 1ns/1ps
module result_formatter
  import adc_cfg_pkg::*;
#(
  parameter int RAW_W = 25,
  parameter int DATA_W = 24
)(
  // raw sample and channel
  input wire logic signed [RAW_W-1:0] rawSample,
  input wire logic [3:0] tag,
  // calibration
  input wire logic [DATA_W-1:0] offset,
  input wire logic [DATA_W-1:0] gain,
  input wire logic offsetEn,
  input wire logic gainEn,
  // layout
  input wire logic [1:0] format,
  output logic [31:0] word
);
  localparam int PW = RAW_W + DATA_W + 2;
  localparam int CW = RAW_W + 3;
  localparam logic signed [CW-1:0] MAX_W = CW'((64'sd1 <<< (RAW_W - 1)) - 1);
  localparam logic signed [CW-1:0] MIN_W = -MAX_W - CW'(1);
  localparam logic signed [CW-1:0] MAX_D = CW'((64'sd1 <<< (DATA_W - 1)) - 1);
  localparam logic signed [CW-1:0] MIN_D = -MAX_D - CW'(1);

  logic signed [RAW_W:0] sum;
  logic signed [PW-1:0] prod;
  logic signed [CW-1:0] corr;
  logic signed [CW-1:0] wide;
  logic [DATA_W-1:0] narrow;

  always_comb
  begin
    sum = (RAW_W+1)'(rawSample);
    if (offsetEn)
      sum = (RAW_W+1)'(rawSample) + (RAW_W+1)'($signed(offset));
    prod = PW'(sum) * PW'($signed({1'b0, gain}));
    corr = CW'(sum);
    if (gainEn)
      corr = CW'(prod >>> (DATA_W - 1));
    wide = corr;
    if (corr > MAX_W)
      wide = MAX_W;
    else if (corr < MIN_W)
      wide = MIN_W;
    narrow = corr[DATA_W-1:0];
    if (corr > MAX_D)
      narrow = SAT_POS;
    else if (corr < MIN_D)
      narrow = SAT_NEG;
    case (format)
      FMT_24: word = {8'h00, narrow};
      FMT_LJ: word = {narrow, 8'h00};
      FMT_SX: word = {{(32-RAW_W){wide[RAW_W-1]}}, wide[RAW_W-1:0]};
      FMT_TAG: word = {tag, {(28-RAW_W){wide[RAW_W-1]}}, wide[RAW_W-1:0]};
      default: word = {8'h00, narrow};
    endcase
  end
endmodule

// ---- verification/adc_cfg_chk.sv ----
// port assertions of the conversion and output config block
// assumes binding to adc_conversion_output_config, one clock sys_clk
`timescale 1ns/1ps
module adc_cfg_chk
  import adc_cfg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // conversion
  input wire logic sampleValid,
  input wire logic shiftBusy,
  input wire logic convActive,
  input wire logic [1:0] opState,
  input wire logic [31:0] resultWord,
  input wire logic resultWide,
  input wire logic resultStrobe,
  // config export
  input wire logic readChecksumEnable,
  input wire logic readChecksumWide,
  input wire logic [7:0] configImage
);
  // ----
  // assertions
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_CFG_RESET: assert property ($fell(sys_rst) |-> configImage == CONFIG_RST)
    else $error("config not zero after reset");
  AST_CKE: assert property (readChecksumEnable == configImage[CFG_CKE_BIT])
    else $error("checksum enable differs");
  AST_CKW: assert property (readChecksumWide == configImage[CFG_CKW_BIT])
    else $error("checksum width differs");
  AST_STBY: assert property (resultStrobe && configImage[7:6] == MODE_STBY
    |-> opState == OP_STBY)
    else $error("no standby after one-shot");
  AST_SHDN: assert property (resultStrobe && !configImage[7] |-> opState == OP_SHDN)
    else $error("no shutdown after one-shot");
  AST_CONT: assert property (resultStrobe && configImage[7:6] == MODE_CONT
    |-> opState == OP_CONV)
    else $error("continuous run stopped");
  AST_FMT24: assert property (resultStrobe && !resultWide
    |-> resultWord[31:24] == 8'h00)
    else $error("24-bit word has upper bits");
  AST_RESULT: assert property (sampleValid && convActive && opState == OP_CONV
    && !shiftBusy |=> resultStrobe)
    else $error("sample gave no result");
  AST_BUSY: assert property (shiftBusy |=> !resultStrobe)
    else $error("result while shifter busy");
  AST_HOLD: assert property (!resultStrobe && !$past(sys_rst) |-> $stable(resultWord))
    else $error("result word changed without strobe");
  cover property (resultStrobe && resultWide);
  cover property (sampleValid && shiftBusy);
  cover property (resultStrobe && opState == OP_CONV);
endmodule

bind adc_conversion_output_config adc_cfg_chk i_chk (
  .sys_clk, .sys_rst, .sampleValid, .shiftBusy, .convActive, .opState, .resultWord,
  .resultWide, .resultStrobe, .readChecksumEnable, .readChecksumWide, .configImage
);

// ---- verification/sample_source_model.sv ----
// sample source and serial shifter stand-in for the config block
// assumes bench commands change just after sys_clk rises
`timescale 1ns/1ps
module sample_source_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bench commands
  input wire logic fireReq,
  input wire logic [24:0] rawIn,
  input wire logic [3:0] tagIn,
  input wire logic busyReq,
  // converter side
  input wire logic convActive,
  output logic sampleValid,
  output logic [24:0] sampleData,
  output logic [3:0] sampleTag,
  output logic shiftBusy
);
  // ----
  // one sample per request, data scrambled while idle
  // ----
  logic pend;
  always_ff @(posedge sys_clk)
  begin
    shiftBusy <= busyReq;
    sampleValid <= 1'h0;
    sampleData <= ~sampleData;
    sampleTag <= ~sampleTag;
    if (fireReq)
      pend <= 1'h1;
    if (sys_rst)
    begin
      pend <= 1'h0;
      sampleData <= 25'h0;
      sampleTag <= 4'h0;
    end
    else if (pend && convActive)
    begin
      sampleValid <= 1'h1;
      sampleData <= rawIn;
      sampleTag <= tagIn;
      pend <= 1'h0;
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the conversion and output config block
// assumes the sample source model on the far side and one 125 MHz clock
`timescale 1ns/1ps
module tb_top;
  import adc_cfg_pkg::*;
  logic sys_clk = 1'h0, sys_rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, fireReq = 1'h0, busyReq = 1'h0;
  logic [24:0] rawIn = 25'h0;
  logic [3:0] tagIn = 4'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire sampleValid, shiftBusy, convStart, convActive, resultWide, resultStrobe;
  wire readChecksumEnable, readChecksumWide;
  wire [1:0] s_axi_bresp, s_axi_rresp, opState;
  wire [31:0] s_axi_rdata, resultWord;
  wire [24:0] sampleData;
  wire [3:0] sampleTag;
  wire [7:0] configImage;
  int errorCnt = 0, compares = 0, cycles = 0, starts = 0, strobes = 0;
  logic [31:0] cal [4] = '{32'h100, 32'h80, 32'h110, 32'h88};

  adc_conversion_output_config i_dut (
    .sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sampleValid, .sampleData, .sampleTag, .convStart, .convActive, .opState,
    .shiftBusy, .resultWord, .resultWide, .resultStrobe, .readChecksumEnable,
    .readChecksumWide, .configImage, .irq
  );
  sample_source_model i_src (
    .sys_clk, .sys_rst, .fireReq, .rawIn, .tagIn, .busyReq, .convActive, .sampleValid,
    .sampleData, .sampleTag, .shiftBusy
  );

  // ----
  // tasks
  // ----
  task automatic stopTest();
    $display("compares %0d errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk($sformatf("bresp %h", a), 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    chk($sformatf("rdata %h", a), e, s_axi_rdata);
    chk($sformatf("rresp %h", a), 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic fire(input logic [24:0] x, input bit w);
    int n;
    n = strobes;
    rawIn <= x;
    tagIn <= ~x[3:0];
    fireReq <= 1'h1;
    @(posedge sys_clk);
    fireReq <= 1'h0;
    while (w && strobes == n)
      @(posedge sys_clk);
  endtask

  task automatic conv(input logic [7:0] c, input logic az, input logic [24:0] x);
    axw(ADDR_CONFIG, 32'(c), RESP_OKAY);
    axw(ADDR_OPCTL, {29'h0, az, 2'h3}, RESP_OKAY);
    fire(x, 1'h1);
  endtask

  function automatic logic [31:0] fmtw(input logic [1:0] f, input logic [24:0] x);
    logic [23:0] s;
    s = (x[24:23] == 2'h1) ? SAT_POS : (x[24:23] == 2'h2) ? SAT_NEG : x[23:0];
    case (f)
      FMT_24: return {8'h00, s};
      FMT_LJ: return {s, 8'h00};
      FMT_SX: return {{8{x[24]}}, x[23:0]};
      default: return {~x[3:0], {4{x[24]}}, x[23:0]};
    endcase
  endfunction

  // ----
  // clock, watchdog, sequence
  // ----
  initial
    forever #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (!sys_rst)
    begin
      starts <= starts + int'(convStart);
      strobes <= strobes + int'(resultStrobe);
    end
    if (cycles == 5000)
    begin
      errorCnt++;
      stopTest();
    end
  end

  initial
  begin
    int n;
    logic [24:0] x;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    axr(ADDR_CONFIG, 32'h0, RESP_OKAY);
    axr(ADDR_IRQ, 32'h40, RESP_OKAY);
    axr(8'h3C, 32'h0, RESP_SLVERR);
    axw(8'h3C, 32'h1, RESP_SLVERR);
    axw(ADDR_CONFIG, 32'hFF, RESP_OKAY);
    axr(ADDR_CONFIG, 32'hFF, RESP_OKAY);
    chk("cke", 32'h1, 32'(readChecksumEnable));
    chk("image", 32'hFF, 32'(configImage));
    axw(ADDR_CONFIG, 32'h08, RESP_OKAY);
    @(posedge sys_clk);
    chk("cke", 32'h0, 32'(readChecksumEnable));
    chk("ckw", 32'h1, 32'(readChecksumWide));
    for (int s = 0; s < 2; s++)
      for (int f = 0; f < 4; f++)
      begin
        x = s ? 25'h1000000 : 25'h0800005;
        conv({2'h2, f[1:0], 4'h0}, 1'h0, x);
        chk("word", fmtw(f[1:0], x), resultWord);
        chk("wide", 32'(f != 0), 32'(resultWide));
        chk("state", 32'(OP_STBY), 32'(opState));
      end
    axw(ADDR_OFFSET, 32'h10, RESP_OKAY);
    axw(ADDR_GAIN, 32'h400000, RESP_OKAY);
    for (int c = 0; c < 4; c++)
    begin
      conv({6'h28, c[1:0]}, 1'h0, 25'h100);
      chk("cal", cal[c], resultWord);
    end
    axw(ADDR_INTCLR, 32'h3, RESP_OKAY);
    for (int m = 0; m < 2; m++)
    begin
      conv({1'h0, m[0], 6'h0}, 1'h0, 25'h123);
      chk("state", 32'(OP_SHDN), 32'(opState));
    end
    chk("irq", 32'h0, 32'(irq));
    axr(ADDR_INTSTAT, 32'h3, RESP_OKAY);
    axr(ADDR_IRQ, 32'h0, RESP_OKAY);
    axw(ADDR_INTEN, 32'h1, RESP_OKAY);
    @(posedge sys_clk);
    chk("irq", 32'h1, 32'(irq));
    axr(ADDR_RESULT, 32'h123, RESP_OKAY);
    axr(ADDR_IRQ, 32'h40, RESP_OKAY);
    axw(ADDR_INTCLR, 32'h1, RESP_OKAY);
    @(posedge sys_clk);
    chk("irq", 32'h0, 32'(irq));
    axr(ADDR_INTSTAT, 32'h2, RESP_OKAY);
    n = starts;
    conv(8'hC0, 1'h0, 25'h55);
    fire(25'h66, 1'h1);
    chk("state", 32'(OP_CONV), 32'(opState));
    chk("active", 32'h1, 32'(convActive));
    chk("starts", 32'(n + 1), 32'(starts));
    axw(ADDR_OPCTL, 32'h0, RESP_OKAY);
    n = starts;
    conv(8'hC0, 1'h1, 25'h55);
    fire(25'h66, 1'h1);
    repeat (3) @(posedge sys_clk);
    chk("starts", 32'(n + 3), 32'(starts));
    axw(ADDR_OPCTL, 32'h0, RESP_OKAY);
    axw(ADDR_CONFIG, 32'hA0, RESP_OKAY);
    axw(ADDR_OPCTL, 32'h3, RESP_OKAY);
    busyReq <= 1'h1;
    axw(ADDR_CONFIG, 32'h80, RESP_OKAY);
    n = strobes;
    fire(25'h1000000, 1'h0);
    repeat (5) @(posedge sys_clk);
    chk("held", 32'(n), 32'(strobes));
    busyReq <= 1'h0;
    while (strobes == n)
      @(posedge sys_clk);
    chk("word", 32'hFF000000, resultWord);
    stopTest();
  end
endmodule
